// ---- mmap_core.sv ----
// Address decoder and storage for code, internal RAM, stack and on-chip external ram.
// Assumes the core issues at most one request per cycle, synchronous to clock.
// Assumes the code store sits outside and answers combinationally in the same cycle.
//
// Contract
// - Large variant code is 15872 bytes from zero
// - Code 0x3E00 upward refused to user reads
// - Small variant has 8192 code bytes
// - Code store read-only, bytes read by loads
// - 256 internal bytes; low half direct/indirect
// - Above 0x7F direct hits SFRs, indirect upper
// - 0x00-0x1F is four banks, one active
// - Bank chosen by status word bits 3,4
// - Bank code n maps to 8n..8n+7
// - Indirect index held in banked zero/one
// - Bytes 0x20-0x2F give bit addresses 0x00-0x7F
// - Bit or byte access by instruction type
// - Push writes pointer plus one, then increments
// - Reset loads stack pointer with 0x07
// - Stack lives anywhere in 256 bytes
// - 1024 external_space_ram bytes by pointer or indirect
// - 8-bit external_space_ram move takes page register high
// - 16-bit external_space_ram ignores top six bits
// - Wide pointer from bytes at 0x82, 0x83
// - Page bits 7:2 read zero, ignore writes
// - Page bits 1:0 select 256-byte page
//
// Limitations: the rams have no reset, so reading a byte before it was ever
// written gives unknown data. The function-register decode only holds the
// registers of this block; every other direct address above 0x7F is refused.
`include "mmap_regs.svh"
module mmap_core #(
  parameter bit BIG_VARIANT = 1'b1  // 1: 15872-byte code store, 0: 8192 bytes
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire mmap_pkg::mm_req_s req,
  input  wire logic [7:0]        code_rdata,
  output logic [15:0]            code_addr,
  output mmap_pkg::mm_rsp_s      rsp,
  output logic [7:0]             stack_top_out,
  output logic [1:0]             bank_out
);
  import mmap_pkg::*;

  // Storage: internal ram and the on-chip external-space ram, both plain flops
  logic [7:0]  iram_r [256];
  logic [7:0]  ext_ram_r [1024];
  // Function registers held by this block
  logic [7:0]  stack_top_r, stack_top_nxt;
  logic [7:0]  status_r, status_nxt;
  logic [7:0]  wptr_lo_r, wptr_lo_nxt;
  logic [7:0]  wptr_hi_r, wptr_hi_nxt;
  logic [1:0]  page_r, page_nxt;
  // Registered answer and code address
  mm_rsp_s     rsp_r, rsp_nxt;
  logic [15:0] caddr_r, caddr_nxt;
  // Storage strobes from the decoder
  logic        ir_we, xr_we;
  logic [7:0]  ir_addr, ir_wd;
  logic [9:0]  xr_addr;
  // Helpers shared by several access kinds
  logic [1:0]  bank;
  logic [7:0]  ptr_addr, bit_byte, push_addr;
  logic [2:0]  bit_pos;
  logic        bit_bad;
  logic [15:0] code_lim;

  // Active bank and the address an indirect access points at
  assign bank     = {status_r[`MMAP_BANK_HI_BIT], status_r[`MMAP_BANK_LO_BIT]};
  assign ptr_addr = (req.ptr_sel == 2'd2) ? req.addr[7:0]
                  : iram_r[{3'b000, bank, 2'b00, req.ptr_sel[0]}];
  // Bit address: byte 0x20 plus bits 6:3, position in bits 2:0
  assign bit_byte = `MMAP_BIT_BASE + {4'h0, req.addr[6:3]};
  assign bit_pos  = req.addr[2:0];
  assign bit_bad  = req.addr[7];  // Bit addresses above 0x7F are not in this ram
  // Pre-increment address; wraps through all 256 bytes on purpose
  assign push_addr = 8'(stack_top_r + 8'h01);
  // Code limit depends on variant; the factory area is never handed out
  assign code_lim = BIG_VARIANT ? `MMAP_CODE_BIG_SIZE : `MMAP_CODE_SMALL;

  // Decode of every request into storage strobes and next register values.
  // Reads see storage before this cycle's write, so a write answers old data.
  always_comb begin
    stack_top_nxt = stack_top_r;
    status_nxt    = status_r;
    wptr_lo_nxt   = wptr_lo_r;
    wptr_hi_nxt   = wptr_hi_r;
    page_nxt      = page_r;
    caddr_nxt     = caddr_r;
    rsp_nxt       = '0;
    ir_we         = 1'b0;
    ir_addr       = 8'h00;
    ir_wd         = req.wdata;
    xr_we         = 1'b0;
    xr_addr       = 10'h000;
    unique case (req.op)
      MM_IDLE: ;
      MM_DIRECT: begin
        rsp_nxt.valid = 1'b1;
        if (req.addr[7:0] < `MMAP_UPPER_BASE) begin
          ir_addr       = req.addr[7:0];
          ir_we         = req.wr;
          rsp_nxt.rdata = iram_r[req.addr[7:0]];
        end else begin
          // Direct above 0x7F goes to the function registers, never the upper ram
          unique case (req.addr[7:0])
            `MMAP_ADDR_STACK: begin
              rsp_nxt.rdata = stack_top_r;
              if (req.wr) stack_top_nxt = req.wdata;
            end
            `MMAP_ADDR_WPTR_LO: begin
              rsp_nxt.rdata = wptr_lo_r;
              if (req.wr) wptr_lo_nxt = req.wdata;
            end
            `MMAP_ADDR_WPTR_HI: begin
              rsp_nxt.rdata = wptr_hi_r;
              if (req.wr) wptr_hi_nxt = req.wdata;
            end
            `MMAP_ADDR_STATUS: begin
              rsp_nxt.rdata = status_r;
              if (req.wr) status_nxt = req.wdata;
            end
            `MMAP_ADDR_PAGE: begin
              rsp_nxt.rdata = {6'b00_0000, page_r};
              if (req.wr) page_nxt = req.wdata[1:0];
            end
            default: rsp_nxt.err = 1'b1; // Registers held elsewhere
          endcase
        end
      end
      MM_INDIR: begin
        // Indirect reaches all 256 bytes, upper half included
        ir_addr       = ptr_addr;
        ir_we         = req.wr;
        rsp_nxt.valid = 1'b1;
        rsp_nxt.rdata = iram_r[ptr_addr];
      end
      MM_BIT: begin
        // Bit operand selects one bit; byte operands use MM_DIRECT
        ir_addr        = bit_byte;
        ir_we          = req.wr && !bit_bad; // A refused bit leaves the ram alone
        ir_wd          = iram_r[bit_byte];
        ir_wd[bit_pos] = req.wdata[0];
        rsp_nxt.valid  = 1'b1;
        rsp_nxt.rdata  = {7'h00, iram_r[bit_byte][bit_pos]};
        rsp_nxt.err    = bit_bad; // Those bits belong to the function registers
      end
      MM_PUSH: begin
        // Write at pointer plus one, then the pointer follows
        ir_addr       = push_addr;
        ir_we         = 1'b1;
        stack_top_nxt = push_addr;
        rsp_nxt.valid = 1'b1;
      end
      MM_EXT8: begin
        // Page register gives address bits 9:8, the index the low byte
        xr_addr       = {page_r, ptr_addr};
        xr_we         = req.wr;
        rsp_nxt.valid = 1'b1;
        rsp_nxt.rdata = ext_ram_r[{page_r, ptr_addr}];
      end
      MM_EXT16: begin
        // Top six pointer bits dropped: ram repeats every 0x0400
        xr_addr       = {wptr_hi_r[1:0], wptr_lo_r};
        xr_we         = req.wr;
        rsp_nxt.valid = 1'b1;
        rsp_nxt.rdata = ext_ram_r[{wptr_hi_r[1:0], wptr_lo_r}];
      end
      MM_CODE: begin
        // Read only: a write or a read of the reserved area is flagged
        caddr_nxt     = req.addr;
        rsp_nxt.valid = 1'b1;
        rsp_nxt.err   = req.wr || (req.addr >= code_lim);
        rsp_nxt.rdata = (req.addr >= code_lim) ? 8'h00 : code_rdata;
      end
    endcase
  end

  // Control registers; reset parks the stack just below bank one
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stack_top_r <= `MMAP_STACK_RESET;
      status_r    <= `MMAP_STATUS_RESET;
      wptr_lo_r   <= `MMAP_WPTR_RESET;
      wptr_hi_r   <= `MMAP_WPTR_RESET;
      page_r      <= 2'(`MMAP_PAGE_RESET);
      rsp_r       <= '0;
      caddr_r     <= 16'h0000;
    end else begin
      stack_top_r <= stack_top_nxt;
      status_r    <= status_nxt;
      wptr_lo_r   <= wptr_lo_nxt;
      wptr_hi_r   <= wptr_hi_nxt;
      page_r      <= page_nxt;
      rsp_r       <= rsp_nxt;
      caddr_r     <= caddr_nxt;
    end
  end

  // Storage arrays, no reset so they map to plain flops without a clear tree
  always_ff @(posedge clock) begin
    if (ir_we) iram_r[ir_addr] <= ir_wd;
    if (xr_we) ext_ram_r[xr_addr] <= req.wdata;
  end

  // Every output comes straight from a register
  assign rsp           = rsp_r;
  assign code_addr     = caddr_r;
  assign stack_top_out = stack_top_r;
  assign bank_out      = {status_r[`MMAP_BANK_HI_BIT], status_r[`MMAP_BANK_LO_BIT]};

  // Checks. Reads of never-written ram bytes are unknown, so the data checks
  // only hold once software has filled what it reads back.

  // Reset value of the stack pointer, seen at the first edge after release
  AST_STACK_RESET: assert property (@(posedge clock)
    $rose(rst_n) |-> stack_top_r == `MMAP_STACK_RESET)
    else $error("stack pointer not at its reset value");

  // Push moves the pointer up by one and leaves the data at the new top
  AST_PUSH_INC: assert property (@(posedge clock) disable iff (!rst_n)
    req.op == MM_PUSH |=> stack_top_r == 8'($past(stack_top_r) + 8'h01))
    else $error("push did not bump stack pointer");
  AST_PUSH_DATA: assert property (@(posedge clock) disable iff (!rst_n)
    req.op == MM_PUSH |=> iram_r[stack_top_r] == $past(req.wdata))
    else $error("push data not at new top");

  // Page register upper bits always read as zero
  AST_PAGE_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
    req.op == MM_DIRECT && req.addr[7:0] == `MMAP_ADDR_PAGE
    |=> rsp.rdata[7:2] == 6'b00_0000)
    else $error("page register upper bits not zero");
  AST_PAGE_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    req.op == MM_DIRECT && req.wr && req.addr[7:0] == `MMAP_ADDR_PAGE
    |=> page_r == $past(req.wdata[1:0]))
    else $error("page field not taken from write");

  // Wide pointer reads alias every 0x0400 bytes
  AST_X16_ALIAS: assert property (@(posedge clock) disable iff (!rst_n)
    req.op == MM_EXT16 && !req.wr
    |=> rsp.rdata == ext_ram_r[{$past(wptr_hi_r[1:0]), $past(wptr_lo_r)}])
    else $error("wide pointer read wrong external ram byte");

  // Eight-bit moves take their high address bits from the page register
  AST_X8_PAGE: assert property (@(posedge clock) disable iff (!rst_n)
    req.op == MM_EXT8 && req.wr |-> xr_addr[9:8] == page_r && xr_addr[7:0] == ptr_addr)
    else $error("page not used for 8-bit move");

  // Wide pointer low byte written through its own function address
  AST_WPTR_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    req.op == MM_DIRECT && req.wr && req.addr[7:0] == `MMAP_ADDR_WPTR_LO
    |=> wptr_lo_r == $past(req.wdata))
    else $error("wide pointer low byte not written");

  // A bit write flips at most the addressed bit
  AST_BIT_KEEP: assert property (@(posedge clock) disable iff (!rst_n)
    req.op == MM_BIT && req.wr && !req.addr[7] |-> (ir_wd ^ iram_r[bit_byte]) ==
      ((req.wdata[0] ^ iram_r[bit_byte][bit_pos]) ? (8'h01 << bit_pos) : 8'h00))
    else $error("bit write touched other bits");

  // A bit request above 0x7F is refused and never writes the ram
  AST_BIT_REFUSE: assert property (@(posedge clock) disable iff (!rst_n)
    req.op == MM_BIT && req.addr[7] |-> !ir_we ##1 rsp.err)
    else $error("refused bit access not flagged");

  // Code store refuses writes and the reserved area
  AST_CODE_RO: assert property (@(posedge clock) disable iff (!rst_n)
    req.op == MM_CODE && req.wr |=> rsp.err)
    else $error("code write not refused");
  AST_FACTORY: assert property (@(posedge clock) disable iff (!rst_n)
    req.op == MM_CODE && BIG_VARIANT && req.addr >= `MMAP_CODE_BIG_SIZE |=> rsp.err)
    else $error("factory area readable");

  // Usable code bytes are handed through unchanged
  AST_CODE_OK: assert property (@(posedge clock) disable iff (!rst_n)
    req.op == MM_CODE && !req.wr && req.addr < code_lim
    |=> !rsp.err && rsp.rdata == $past(code_rdata) && code_addr == $past(req.addr))
    else $error("usable code byte not handed through");

  // Indirect accesses always land in internal ram
  AST_INDIR_UP: assert property (@(posedge clock) disable iff (!rst_n)
    req.op == MM_INDIR && req.wr |-> !xr_we && ir_we && ir_addr == ptr_addr)
    else $error("indirect did not hit internal ram");

  // Direct above 0x7F never touches the upper ram
  AST_DIRECT_UP: assert property (@(posedge clock) disable iff (!rst_n)
    req.op == MM_DIRECT && req.addr[7:0] >= `MMAP_UPPER_BASE |-> !ir_we)
    else $error("direct access reached upper ram");

  // Function registers not held here answer with an error
  AST_DIRECT_ERR: assert property (@(posedge clock) disable iff (!rst_n)
    req.op == MM_DIRECT && req.addr[7:0] >= `MMAP_UPPER_BASE
    && !(req.addr[7:0] inside {`MMAP_ADDR_STACK, `MMAP_ADDR_WPTR_LO, `MMAP_ADDR_WPTR_HI,
    `MMAP_ADDR_STATUS, `MMAP_ADDR_PAGE}) |=> rsp.err)
    else $error("unheld function register not refused");

  // Banked register one of the active bank supplies the index
  AST_BANK_PTR: assert property (@(posedge clock) disable iff (!rst_n)
    req.op == MM_INDIR && req.ptr_sel == 2'd1 |-> ir_addr == iram_r[{3'b000, bank_out, 3'b001}])
    else $error("index not taken from active bank");
endmodule

// ---- mmap_regs.svh ----
// Offsets, field positions, reset values and sizes for the memory map block.
// Assumes inclusion by the package and the design module only.
`ifndef MMAP_REGS_SVH
`define MMAP_REGS_SVH
`define MMAP_ADDR_PAGE      8'hAA
`define MMAP_ADDR_STACK     8'h81
`define MMAP_ADDR_WPTR_LO   8'h82
`define MMAP_ADDR_WPTR_HI   8'h83
`define MMAP_ADDR_STATUS    8'hD0
`define MMAP_PAGE_RESET     8'h00
`define MMAP_STACK_RESET    8'h07
`define MMAP_STATUS_RESET   8'h00
`define MMAP_WPTR_RESET     8'h00
`define MMAP_BANK_LO_BIT    3
`define MMAP_BANK_HI_BIT    4
`define MMAP_PAGE_MASK      8'h03
`define MMAP_BIT_BASE       8'h20
`define MMAP_BIT_TOP        8'h2F
`define MMAP_UPPER_BASE     8'h80
`define MMAP_CODE_BIG_SIZE  16'h3E00
`define MMAP_CODE_BIG_TOP   16'h3FFF
`define MMAP_CODE_SMALL     16'h2000
`endif

// ---- mmap_pkg.sv ----
// Types shared by the memory map block.
// Assumes the constants header sits in the same folder.
package mmap_pkg;
  `include "mmap_regs.svh"
  // Kind of access the core is making
  typedef enum logic [2:0] {
    MM_IDLE    = 3'b000,
    MM_DIRECT  = 3'b001,
    MM_INDIR   = 3'b011,
    MM_BIT     = 3'b010,
    MM_EXT8    = 3'b110,
    MM_EXT16   = 3'b111,
    MM_CODE    = 3'b101,
    MM_PUSH    = 3'b100
  } mm_op_e;
  // One access request from the core
  typedef struct packed {
    mm_op_e     op;
    logic       wr;
    logic [1:0] ptr_sel;  // Indirect: 0 uses banked_reg_zero, 1 banked_reg_one, 2 the address
    logic [15:0] addr;
    logic [7:0] wdata;
  } mm_req_s;
  // Answer to the core
  typedef struct packed {
    logic       valid;
    logic       err;
    logic [7:0] rdata;
  } mm_rsp_s;
endpackage

// ---- mmap_code_rom.sv ----
// Code store model standing outside the memory map block.
// Assumes the block gates refused addresses; this store answers any address.
module mmap_code_rom (
  input  wire mmap_pkg::mm_req_s req,
  output logic [7:0]             code_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import mmap_pkg::*;
  // Pattern from both address bytes so a wrong fetch address shows
  assign code_rdata = req.addr[7:0] ^ req.addr[15:8];
endmodule

// ---- tb.sv ----
// Self-checking bench for the memory map block.
// Assumes one answer per request, exactly one cycle after it is taken.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mmap_pkg::*;
  typedef struct {logic [7:0] m; logic e; logic [7:0] d;} mm_note_s;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  mm_req_s     req;
  mm_rsp_s     rsp;
  logic [7:0]  code_rdata, stack_top_out, d, b, h;
  logic [15:0] code_addr;
  logic [1:0]  bank_out;
  int          errors = 0;
  int          check_count = 0;
  int          p;
  mm_note_s    notes[$];
  mm_note_s    n;
  mmap_core #(.BIG_VARIANT(1'b1)) dut_u (.clock(clock), .rst_n(rst_n), .req(req),
    .code_rdata(code_rdata), .code_addr(code_addr), .rsp(rsp), .stack_top_out(stack_top_out),
    .bank_out(bank_out));
  mmap_code_rom rom_u (.req(req), .code_rdata(code_rdata));
  // Free-running clock
  initial begin
    forever #10 clock = ~clock;
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Drive one request for one cycle and note what the answer must be
  task acc(input mm_op_e op, input logic wr, input logic [1:0] ps, input logic [15:0] a,
           input logic [7:0] wd, input logic e, input logic [7:0] m, input logic [7:0] x);
    req = '{op, wr, ps, a, wd};
    notes.push_back('{m, e, x});
    @(negedge clock);
  endtask
  // Answers are registered, so look a little after the edge
  always @(posedge clock) begin
    #1;
    if (rsp.valid === 1'b1) begin
      if (notes.size() == 0) begin
        check(8'h01, 8'h00);
      end else begin
        n = notes.pop_front();
        check({7'h00, rsp.err}, {7'h00, n.e});
        check(rsp.rdata & n.m, n.d & n.m);
      end
    end
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    results();
  end
  initial begin
    req = '0;
    void'($urandom(81));
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    check(stack_top_out, 8'h07);
    check({6'h00, bank_out}, 8'h00);
    acc(MM_DIRECT, 0, 0, 16'h00aa, 0, 0, 8'hff, 8'h00);
    d = 8'($urandom);
    acc(MM_PUSH, 0, 0, 0, d, 0, 0, 0);
    check(stack_top_out, 8'h08);
    acc(MM_INDIR, 0, 2, 16'h0008, 0, 0, 8'hff, d);
    acc(MM_DIRECT, 1, 0, 16'h00aa, 8'hff, 0, 0, 0);
    acc(MM_DIRECT, 0, 0, 16'h00aa, 0, 0, 8'hff, 8'h03);
    // Each page: junk in the unused bits must not matter
    for (p = 0; p < 4; p++) begin
      d = 8'($urandom);
      b = 8'($urandom);
      h = {6'($urandom), p[1:0]};
      acc(MM_DIRECT, 1, 0, 16'h00aa, {6'($urandom), p[1:0]}, 0, 0, 0);
      acc(MM_EXT8, 1, 2, {8'h00, b}, d, 0, 0, 0);
      acc(MM_DIRECT, 1, 0, 16'h0083, h, 0, 0, 0);
      acc(MM_DIRECT, 1, 0, 16'h0082, b, 0, 0, 0);
      acc(MM_EXT16, 0, 0, 0, 0, 0, 8'hff, d);
    end
    // Each bank: banked register one of the active bank holds the index
    for (p = 0; p < 4; p++) begin
      d = 8'($urandom);
      acc(MM_DIRECT, 1, 0, 16'h00d0, {3'h0, p[1:0], 3'h0}, 0, 0, 0);
      check({6'h00, bank_out}, 8'(p));
      acc(MM_DIRECT, 1, 0, {11'h000, p[1:0], 3'h1}, {6'h10, p[1:0]}, 0, 0, 0);
      acc(MM_INDIR, 1, 1, 0, d, 0, 0, 0);
      acc(MM_DIRECT, 0, 0, {8'h00, 6'h10, p[1:0]}, 0, 0, 8'hff, d);
    end
    acc(MM_INDIR, 1, 2, 16'h0083, 8'h5a, 0, 0, 0);
    acc(MM_DIRECT, 0, 0, 16'h0083, 0, 0, 8'hff, h);
    acc(MM_INDIR, 0, 2, 16'h0083, 0, 0, 8'hff, 8'h5a);
    acc(MM_DIRECT, 1, 0, 16'h0022, 8'h00, 0, 0, 0);
    acc(MM_BIT, 1, 0, 16'h0013, 8'h01, 0, 0, 0);
    acc(MM_DIRECT, 0, 0, 16'h0022, 0, 0, 8'hff, 8'h08);
    acc(MM_BIT, 0, 0, 16'h0013, 0, 0, 8'h01, 8'h01);
    acc(MM_BIT, 0, 0, 16'h0080, 0, 1, 0, 0);
    acc(MM_DIRECT, 1, 0, 16'h0020, 8'h00, 0, 0, 0);
    acc(MM_BIT, 1, 0, 16'h0080, 8'h01, 1, 0, 0);
    acc(MM_DIRECT, 0, 0, 16'h0020, 0, 0, 8'hff, 8'h00);
    acc(MM_CODE, 0, 0, 16'h3dff, 0, 0, 8'hff, 8'hc2);
    check(code_addr[15:8], 8'h3d);
    acc(MM_CODE, 0, 0, 16'h3e00, 0, 1, 0, 0);
    acc(MM_CODE, 1, 0, 16'h0010, 8'h55, 1, 0, 0);
    acc(MM_DIRECT, 0, 0, 16'h0084, 0, 1, 0, 0);
    req.op = MM_IDLE;
    repeat (3) @(negedge clock);
    check(8'(notes.size()), 8'h00);
    results();
  end
endmodule
